// ==== hw/dram_training_fifo_dqs_osc.sv ====
// Training FIFO and DQS interval oscillator of the memory device.
`timescale 1ns/1ps
`default_nettype none
module dram_training_fifo_dqs_osc (
    input  wire logic                                  core_clk_i,
    input  wire logic                                  rst_n_i,
    input  wire logic                                  multi_purpose_command_i,
    input  wire logic [6:0]                            mpc_op_i,
    input  wire logic                                  cas2_i,
    input  wire logic [dram_training_pkg::LAT_W-1:0]   read_latency_i,
    input  wire logic [dram_training_pkg::LAT_W-1:0]   write_latency_i,
    input  wire logic [dram_training_pkg::DQ_WIDTH-1:0] dq_i,
    input  wire logic [1:0]                            mask_inversion_pins_i,
    input  wire logic                                  write_bus_inversion_enable_i,
    input  wire logic                                  read_bus_inversion_enable_i,
    input  wire logic                                  data_mask_enable_i,
    input  wire logic [7:0]                            oscillator_run_timer_i,
    input  wire logic                                  replica_tick_i,
    output logic [dram_training_pkg::DQ_WIDTH-1:0]     dq_o,
    output logic                                       dq_oe_n_o,
    output logic [1:0]                                 mask_inversion_pins_o,
    output logic                                       mask_inversion_oe_n_o,
    output logic                                       termination_on_o,
    output logic [7:0]                                 oscillator_count_low_o,
    output logic [7:0]                                 oscillator_count_high_o,
    output logic                                       oscillator_running_o
);
    import dram_training_pkg::*;

    // ************************************************************
    // Command decode
    // ************************************************************
    logic [6:0]              pend_op;
    logic                    pend_valid;
    logic                    rd_cmd;
    logic                    wr_cmd;
    logic                    osc_go;
    logic                    osc_stop_cmd;

    // Data commands wait for the following column command; oscillator ones act at once.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_op    <= 7'h00;
            pend_valid <= 1'b0;
        end else begin
            pend_valid <= multi_purpose_command_i && (mpc_op_i == OP_RD_FIFO || mpc_op_i == OP_WR_FIFO);
            pend_op    <= mpc_op_i;
        end
    end

    assign rd_cmd       = pend_valid && cas2_i && (pend_op == OP_RD_FIFO);
    assign wr_cmd       = pend_valid && cas2_i && (pend_op == OP_WR_FIFO);
    assign osc_go       = multi_purpose_command_i && (mpc_op_i == OP_OSC_GO);
    assign osc_stop_cmd = multi_purpose_command_i && (mpc_op_i == OP_OSC_STOP);

    // ************************************************************
    // Latency shift lines
    // ************************************************************
    // One bit per cycle of latency; a burst starts when its bit reaches the chosen tap.
    logic [63:0] rd_line;
    logic [63:0] wr_line;
    logic        rd_start;
    logic        wr_start;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_line <= 64'h0;
            wr_line <= 64'h0;
        end else begin
            rd_line <= {rd_line[62:0], rd_cmd};
            wr_line <= {wr_line[62:0], wr_cmd};
        end
    end

    assign rd_start = rd_line[read_latency_i];
    assign wr_start = wr_line[write_latency_i];

    // ************************************************************
    // FIFO storage and pointers
    // ************************************************************
    logic [DQ_WIDTH-1:0] fifo_mem [FIFO_DEPTH][BURST_LEN];
    logic [1:0]          mask_mem [FIFO_DEPTH][BURST_LEN];
    logic [PTR_W-1:0]    wr_ptr;
    logic [PTR_W-1:0]    rd_ptr;
    logic [PTR_W-1:0]    wr_entry;
    logic [PTR_W-1:0]    rd_entry;
    logic [4:0]          wr_beat;
    logic [4:0]          rd_beat;
    logic                wr_busy;
    logic                rd_busy;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= PTR_RESET;
            rd_ptr <= PTR_RESET;
        end else begin
            if (wr_cmd) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? PTR_RESET : wr_ptr + 3'h1;
            end
            if (rd_cmd) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? PTR_RESET : rd_ptr + 3'h1;
            end
        end
    end

    // Write burst capture; back-to-back bursts restart the beat count seamlessly.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_busy  <= 1'b0;
            wr_beat  <= 5'h00;
            wr_entry <= PTR_RESET;
        end else if (wr_start) begin
            wr_busy  <= 1'b1;
            wr_beat  <= 5'h01;
            wr_entry <= wr_entry;
        end else if (wr_busy) begin
            wr_busy <= (wr_beat != BEAT_LAST);
            wr_beat <= wr_beat + 5'h01;
            if (wr_beat == BEAT_LAST) begin
                wr_entry <= (wr_entry == PTR_LAST) ? PTR_RESET : wr_entry + 3'h1;
            end
        end
    end

    // Storage has no reset, so entries never written read back undefined.
    always_ff @(posedge core_clk_i) begin
        if (wr_start) begin
            fifo_mem[wr_entry][0] <= dq_i;
            mask_mem[wr_entry][0] <= mask_inversion_pins_i;
        end else if (wr_busy) begin
            fifo_mem[wr_entry][wr_beat[3:0]] <= dq_i;
            mask_mem[wr_entry][wr_beat[3:0]] <= mask_inversion_pins_i;
        end
    end

    // Read bursts never modify storage.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_busy  <= 1'b0;
            rd_beat  <= 5'h00;
            rd_entry <= PTR_RESET;
        end else if (rd_start) begin
            rd_busy  <= 1'b1;
            rd_beat  <= 5'h01;
            rd_entry <= rd_entry;
        end else if (rd_busy) begin
            rd_busy <= (rd_beat != BEAT_LAST);
            rd_beat <= rd_beat + 5'h01;
            if (rd_beat == BEAT_LAST) begin
                rd_entry <= (rd_entry == PTR_LAST) ? PTR_RESET : rd_entry + 3'h1;
            end
        end
    end

    logic mask_drive;
    assign mask_drive = write_bus_inversion_enable_i || read_bus_inversion_enable_i || data_mask_enable_i;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_o                  <= '0;
            dq_oe_n_o             <= 1'b1;
            mask_inversion_pins_o <= 2'h0;
            mask_inversion_oe_n_o <= 1'b1;
        end else if (rd_start || rd_busy) begin
            dq_o                  <= fifo_mem[rd_entry][rd_start ? 4'h0 : rd_beat[3:0]];
            dq_oe_n_o             <= 1'b0;
            mask_inversion_pins_o <= mask_mem[rd_entry][rd_start ? 4'h0 : rd_beat[3:0]];
            mask_inversion_oe_n_o <= !mask_drive;
        end else begin
            dq_oe_n_o             <= 1'b1;
            mask_inversion_oe_n_o <= 1'b1;
        end
    end

    // Termination is registered from the write capture window, so it trails write latency by one cycle.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            termination_on_o <= 1'b0;
        end else begin
            termination_on_o <= wr_start || wr_busy;
        end
    end

    // ************************************************************
    // Interval oscillator
    // ************************************************************
    osc_state_t  osc_state;
    logic [15:0] osc_count;
    logic [7:0]  run_clocks;
    logic        tick_meta;
    logic        tick_sync;
    logic        tick_prev;
    logic        osc_end;

    // The replica ring runs asynchronously, so its tick is synchronised first.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_prev <= 1'b0;
        end else begin
            tick_meta <= replica_tick_i;
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
        end
    end

    assign osc_end = (osc_state == OSC_RUN) &&
                     ((oscillator_run_timer_i == TIMER_OFF) ? osc_stop_cmd
                                                             : (run_clocks == oscillator_run_timer_i));

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_state  <= OSC_IDLE;
            osc_count  <= OSC_RESET;
            run_clocks <= 8'h00;
        end else begin
            case (osc_state)
                OSC_IDLE: begin
                    if (osc_go) begin
                        osc_state  <= OSC_RUN;
                        osc_count  <= OSC_RESET;
                        run_clocks <= 8'h01;
                    end
                end
                OSC_RUN: begin
                    if (osc_end) begin
                        osc_state <= OSC_IDLE;
                    end else begin
                        run_clocks <= run_clocks + 8'h01;
                        if (tick_sync && !tick_prev && osc_count != OSC_MAX) begin
                            osc_count <= osc_count + 16'h0001;
                        end
                    end
                end
                default: begin
                    osc_state <= OSC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oscillator_count_low_o  <= 8'h00;
            oscillator_count_high_o <= 8'h00;
        end else if (osc_end) begin
            oscillator_count_low_o  <= osc_count[7:0];
            oscillator_count_high_o <= osc_count[15:8];
        end
    end

    assign oscillator_running_o = (osc_state == OSC_RUN);

    // ************************************************************
    // Checks
    // ************************************************************
    AST_PTR_WRAP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_cmd && rd_ptr == PTR_LAST |=> rd_ptr == PTR_RESET) else $error("read pointer did not wrap");
    AST_PTR_RANGE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_ptr <= PTR_LAST && rd_ptr <= PTR_LAST) else $error("pointer out of range");
    AST_SATURATE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        osc_count == OSC_MAX && osc_state == OSC_RUN |=> osc_count == OSC_MAX) else $error("counter wrapped");
    AST_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        osc_go && osc_state == OSC_IDLE |=> osc_count == OSC_RESET && oscillator_running_o) else $error("no clear");
    AST_STORE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        osc_end |=> {oscillator_count_high_o, oscillator_count_low_o} == $past(osc_count)) else $error("not stored");
    AST_AUTO_STOP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        oscillator_running_o && oscillator_run_timer_i != TIMER_OFF && run_clocks == oscillator_run_timer_i
        |=> !oscillator_running_o) else $error("timer stop missed");
    AST_MANUAL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        oscillator_running_o && oscillator_run_timer_i == TIMER_OFF && !osc_stop_cmd
        |=> oscillator_running_o) else $error("stopped without command");
    AST_MASK_DRIVE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !dq_oe_n_o && mask_drive && $stable(mask_drive) |-> !mask_inversion_oe_n_o) else $error("mask pins idle");
    AST_READ_LAT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_start |=> !dq_oe_n_o [*8]) else $error("burst short");
endmodule : dram_training_fifo_dqs_osc
`default_nettype wire

// ==== hw/dram_training_pkg.sv ====
// Constants for the training FIFO and interval oscillator block.
package dram_training_pkg;
    localparam int unsigned FIFO_DEPTH  = 5;
    localparam int unsigned BURST_LEN   = 16;
    localparam int unsigned DQ_WIDTH    = 16;
    localparam int unsigned PTR_W       = 3;
    localparam int unsigned LAT_W       = 6;
    localparam logic [6:0]  OP_RD_FIFO  = 7'h41;
    localparam logic [6:0]  OP_WR_FIFO  = 7'h47;
    localparam logic [6:0]  OP_OSC_GO   = 7'h4b;
    localparam logic [6:0]  OP_OSC_STOP = 7'h4d;
    localparam logic [PTR_W-1:0] PTR_RESET   = 3'h0;
    localparam logic [PTR_W-1:0] PTR_LAST    = 3'h4;
    localparam logic [15:0] OSC_MAX     = 16'hffff;
    localparam logic [15:0] OSC_RESET   = 16'h0000;
    localparam logic [7:0]  TIMER_OFF   = 8'h00;
    localparam logic [4:0]  BEAT_LAST   = 5'h0f;
    // Stop-to-readout wait, enforced by the controller.
    localparam int unsigned OSC_READOUT_NS   = 40;
    localparam int unsigned OSC_READOUT_CK   = 8;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned OSC_READOUT_CYC  =
        ((OSC_READOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS > OSC_READOUT_CK) ?
        (OSC_READOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS : OSC_READOUT_CK;
    typedef enum logic [1:0] {
        OSC_IDLE = 2'b00,
        OSC_RUN  = 2'b01
    } osc_state_t;
endpackage : dram_training_pkg

// ==== tb/mem_ctrl_model.sv ====
// Memory controller model that drives the training command, data and replica pins.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
    input  wire logic        core_clk_i,
    output logic             mpc_o,
    output logic [6:0]       op_o,
    output logic             cas2_o,
    output logic [15:0]      dq_o,
    output logic [1:0]       mask_o,
    output logic             tick_o
);
    import dram_training_pkg::*;
    logic tick_en;
    initial begin
        {mpc_o, op_o, cas2_o, dq_o, mask_o, tick_o, tick_en} = '0;
    end
    // The replica stand-in is slower than the core clock, so no edge is lost in the synchroniser.
    always #17 tick_o = tick_en & ~tick_o;
    // Callers enter just after a clock edge; the command is taken at the next edge.
    task automatic cmd(input logic [6:0] op, input logic two);
        mpc_o = 1'b1;
        op_o = op;
        @(posedge core_clk_i);
        #1 mpc_o = 1'b0;
        op_o = ~op;
        cas2_o = two; // the column operands are not modelled; op_o carries the inverted command code
        @(posedge core_clk_i);
        #1 cas2_o = 1'b0;
    endtask : cmd
    task automatic write_burst(input logic [17:0] b [16], input int wl);
        cmd(OP_WR_FIFO, 1'b1); // never issued close to a power-down exit
        repeat (wl) @(posedge core_clk_i);
        for (int k = 0; k < 16; k++) begin
            #1 {mask_o, dq_o} = b[k];
            @(posedge core_clk_i);
        end
        // Released lines show the inverse so a late sample cannot match by luck.
        #1 {mask_o, dq_o} = ~{mask_o, dq_o};
    endtask : write_burst
    task automatic osc_stop();
        cmd(OP_OSC_STOP, 1'b0); // only called while the run timer is zero
        repeat (OSC_READOUT_CYC) @(posedge core_clk_i);
        #1;
    endtask : osc_stop
endmodule : mem_ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench for the training FIFO and interval oscillator.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dram_training_pkg::*;
    logic clk, rst_n, multi_purpose_command, cas2, tick, wdbi, rdbi, dmen, oe_n, moe_n, term, run_o;
    logic [6:0]  op;
    logic [5:0]  rl, wl;
    logic [15:0] dq_in, dq_out, cnt;
    logic [1:0]  m_in, m_out;
    logic [7:0]  timer, c_lo, c_hi;
    logic [31:0] seed;
    logic [17:0] mem [5][16];
    logic [17:0] beats [16];
    logic [17:0] exp_q [$];
    int          starts [$];
    int          runs [$];
    int          num_errors, checks, cyc, beat, run, tcnt, nt, n;
    mem_ctrl_model ctrl (.core_clk_i(clk), .mpc_o(multi_purpose_command), .op_o(op), .cas2_o(cas2), .dq_o(dq_in),
        .mask_o(m_in), .tick_o(tick));
    dram_training_fifo_dqs_osc uut (.core_clk_i(clk), .rst_n_i(rst_n), .multi_purpose_command_i(multi_purpose_command),
        .mpc_op_i(op), .cas2_i(cas2), .read_latency_i(rl), .write_latency_i(wl), .dq_i(dq_in),
        .mask_inversion_pins_i(m_in), .write_bus_inversion_enable_i(wdbi),
        .read_bus_inversion_enable_i(rdbi), .data_mask_enable_i(dmen), .oscillator_run_timer_i(timer),
        .replica_tick_i(tick), .dq_o(dq_out), .dq_oe_n_o(oe_n), .mask_inversion_pins_o(m_out),
        .mask_inversion_oe_n_o(moe_n), .termination_on_o(term), .oscillator_count_low_o(c_lo),
        .oscillator_count_high_o(c_hi), .oscillator_running_o(run_o));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // ****************************************
    // Clock, counters and read-side monitor
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge tick) if (run_o === 1'b1) nt++;
    always @(negedge clk) begin
        logic [17:0] e;
        if (term === 1'b1) tcnt++;
        if (oe_n === 1'b0) begin
            if (beat == 0) check(18'(cyc), 18'(starts.pop_front()));
            e = exp_q.pop_front();
            if (!(wdbi | rdbi | dmen)) e[17:16] = 2'h0;
            check(moe_n, 18'(!(wdbi | rdbi | dmen)));
            check({(moe_n ? 2'h0 : m_out), dq_out}, e);
            beat = (beat + 1) % 16;
            run++;
        end else if (run != 0) begin
            runs.push_back(run);
            run = 0;
        end
    end
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {num_errors, checks, cyc, beat, run, tcnt, nt} = '0;
        {rst_n, wdbi, rdbi, dmen} = '0;
        rl = 6'h05;
        wl = 6'h03;
        timer = 8'h00;
        seed = 32'h07ee2ce3;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int w = 0; w < 5; w++) begin
            for (int k = 0; k < 16; k++) begin
                seed = lfsr(seed);
                beats[k] = seed[17:0];
                mem[w][k] = seed[17:0];
            end
            ctrl.write_burst(beats, int'(wl));
            repeat (4) @(posedge clk);
            #1;
        end
        check(18'(tcnt), 18'h50);
        $display("test fifo_write done");
        // Each group reads all entries seamlessly under another latency and mask setting.
        for (int g = 0; g < 4; g++) begin
            {wdbi, rdbi, dmen} = 3'((g == 0) ? 0 : 4 >> (g - 1));
            rl = 6'(3 + g);
            for (int r = 0; r < 5; r++) begin
                starts.push_back(cyc + 3 + int'(rl));
                for (int k = 0; k < 16; k++) exp_q.push_back(mem[r][k]);
                ctrl.cmd(OP_RD_FIFO, 1'b1);
                repeat (14) @(posedge clk);
                #1;
            end
            repeat (30) @(posedge clk);
            #1;
            check(18'(runs.pop_front()), 18'h50);
        end
        $display("test fifo_read done");
        ctrl.tick_en = 1'b1;
        nt = 0;
        ctrl.cmd(OP_OSC_GO, 1'b0);
        check(run_o, 18'h1);
        repeat (60) @(posedge clk);
        #1 ctrl.osc_stop();
        cnt = {c_hi, c_lo};
        check(run_o, 18'h0);
        check(18'(cnt + 2 >= nt && cnt <= nt + 2 && nt > 10), 18'h1);
        check(18'(cnt != OSC_MAX), 18'h1);
        ctrl.tick_en = 1'b0;
        // A replica edge just before the start would still be in the synchroniser, so let it drain.
        repeat (4) @(posedge clk);
        #1 ctrl.cmd(OP_OSC_GO, 1'b0);
        repeat (20) @(posedge clk);
        #1 ctrl.osc_stop();
        check({c_hi, c_lo}, 18'h0);
        $display("test osc_command done");
        timer = 8'h14;
        ctrl.tick_en = 1'b1;
        nt = 0;
        n = 0;
        ctrl.cmd(OP_OSC_GO, 1'b0);
        while (run_o === 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        repeat (10) @(posedge clk);
        #1 cnt = {c_hi, c_lo};
        check(18'(n >= 19 && n <= 21), 18'h1);
        check(18'(cnt + 2 >= nt && cnt <= nt + 2 && nt > 3), 18'h1);
        $display("test osc_timer done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
